// File: dps_consts.vh
// Constants for the dual rail power state sequencer.
// Notes on behaviour
// - Below power-on threshold: no power, registers reset.
// - Undervoltage resets all but fault-cause flags.
// - Leave undervoltage only above threshold plus hysteresis.
// - Shutdown: serial on; enable low discharges outputs.
// - Wake on enable, force-on bits or bias-keep.
// - Bias on: bias blocks on, regulators off except forced-on rails.
// - Enable, bias good, no fault, no force: power-up delay.
// - Power-up delay expiry sets done flags, regulators on.
// - Enable low starts power-down for done, unforced rails.
// - Each rail times its own power-down delay.
// - Enable high plus force-on aborts power-down.
// - Power-down touches only rails that are on.
// - Power-down expiry clears both done flags.
// - Error input fall with enable, rails on: error.
// - Error: regulators off, discharge per rail enables.
// - Leave error when input high and force-off clear.
// - No wake source: power down, back to shutdown.
// - Lockout or bias fault: rails off at once.
// - Below power-on threshold from anywhere: no power.
// - Force-on turns rail on undelayed, clears done flag.
// - Error fall sets error status and force-off.
`ifndef DPS_CONSTS_VH
`define DPS_CONSTS_VH
// ----------------------------------------------------------------------
// States
// ----------------------------------------------------------------------
`define DPS_ST_NOPWR 3'h0
`define DPS_ST_UVLO 3'h1
`define DPS_ST_SHDN 3'h2
`define DPS_ST_BIAS 3'h3
`define DPS_ST_PUDLY 3'h4
`define DPS_ST_RSON 3'h5
`define DPS_ST_PDDLY 3'h6
`define DPS_ST_ERROR 3'h7
// ----------------------------------------------------------------------
// Register offsets and fields
// ----------------------------------------------------------------------
`define DPS_A_GLOBAL_CONFIG 4'h0
`define DPS_A_CONVERTER_CONFIG 4'h1
`define DPS_A_GLOBAL_STATUS 4'h2
`define DPS_A_FAULT_CAUSE 4'h3
`define DPS_A_POS_UP_DELAY 4'h4
`define DPS_A_NEG_UP_DELAY 4'h5
`define DPS_A_POS_OFF_DELAY 4'h6
`define DPS_A_NEG_OFF_DELAY 4'h7
`define DPS_B_FORCE_POS_ON 0
`define DPS_B_FORCE_NEG_ON 1
`define DPS_B_BIAS_KEEP 2
`define DPS_B_FORCE_OFF 3
`define DPS_B_POS_DIS 0
`define DPS_B_NEG_DIS 1
`define DPS_B_UVLO_F 0
`define DPS_B_OVLO_F 1
`define DPS_B_OTLO_F 2
// ----------------------------------------------------------------------
// Reset values, delays in units of one tick
// ----------------------------------------------------------------------
`define DPS_RST_DELAY 8'h04
`define DPS_TICK_NS 1000
`define DPS_CLK_NS 10
`define DPS_TICK_CYC (`DPS_TICK_NS / `DPS_CLK_NS)
`endif

// File: dps_host.sv
// Host model: drives the enable pin and the register port.
module dps_host (
   input wire core_clk, // clock
   output logic enable_pin, // enable pin
   output logic [3:0] reg_addr, // address
   output logic [7:0] reg_wdata, // write data
   output logic reg_wr, // write strobe
   output logic reg_rd, // read strobe
   input wire [7:0] reg_rdata // read data
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      enable_pin = 1'h0;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'h0;
      reg_rd = 1'h0;
   end
   // Data is inverted once the strobe drops so stale values never help.
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge core_clk);
      reg_wr <= 1'h0;
      reg_wdata <= ~d;
   endtask
   task rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge core_clk);
      reg_rd <= 1'h0;
      @(posedge core_clk);
      d = reg_rdata;
   endtask
   task en(input logic v);
      @(posedge core_clk);
      enable_pin <= v;
   endtask
endmodule

// File: dps_seq_sva.sv
// Port checker for the dual rail power state sequencer.
`include "dps_consts.vh"
module dps_seq_sva (
   input wire core_clk, // clock
   input wire rst_n, // reset, active low
   input wire por_ok, // above power-on level
   input wire otlo, // overtemperature lockout
   input wire enable_pin, // enable pin
   input wire pos_reg_en, // positive enable
   input wire neg_reg_en, // negative enable
   input wire pos_discharge, // positive discharge
   input wire neg_discharge, // negative discharge
   input wire bias_en, // bias on
   input wire serial_en, // serial on
   input wire regs_reset, // register reset
   input wire pos_rail_up_done, // positive done
   input wire neg_rail_up_done, // negative done
   input wire [2:0] state // state
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   // -------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------
   a_nopwr_held: assert property (
      state == `DPS_ST_NOPWR |-> regs_reset && !serial_en)
      else $error("registers live without power");
   a_shdn_discharge: assert property (
      (state == `DPS_ST_SHDN && !enable_pin)[*5]
      |-> pos_discharge && neg_discharge)
      else $error("no discharge in shutdown");
   a_pudly_rails_off: assert property (
      state == `DPS_ST_PUDLY |-> bias_en && !pos_reg_en && !neg_reg_en)
      else $error("rails on before delay end");
   a_rson_entry: assert property (
      $past(state) == `DPS_ST_PUDLY && state == `DPS_ST_RSON
      |-> pos_rail_up_done && neg_rail_up_done && pos_reg_en && neg_reg_en)
      else $error("resource on without done flags");
   a_pddly_exit: assert property (
      $past(state) == `DPS_ST_PDDLY && state != `DPS_ST_PDDLY
      && state != `DPS_ST_RSON |-> !pos_rail_up_done && !neg_rail_up_done)
      else $error("done flags kept after power down");
   a_error_entry: assert property (
      state == `DPS_ST_ERROR && $past(state) != `DPS_ST_ERROR
      |-> $past(pos_reg_en) && $past(neg_reg_en))
      else $error("error entered with rails off");
   a_error_rails: assert property (
      state == `DPS_ST_ERROR |-> !pos_reg_en && !neg_reg_en)
      else $error("rails on in error");
   a_lockout_off: assert property (
      otlo[*5] |-> !pos_reg_en && !neg_reg_en)
      else $error("rails on under lockout");
   a_por_drop: assert property (
      (!por_ok)[*5] |-> state == `DPS_ST_NOPWR)
      else $error("powered state below power-on level");
   c_rson: cover property (state == `DPS_ST_RSON);
   c_pddly: cover property (state == `DPS_ST_PDDLY);
   c_error: cover property (state == `DPS_ST_ERROR);
endmodule
bind dps_sequencer dps_seq_sva dps_seq_sva_i (.core_clk(core_clk),
   .rst_n(rst_n), .por_ok(por_ok), .otlo(otlo), .enable_pin(enable_pin),
   .pos_reg_en(pos_reg_en), .neg_reg_en(neg_reg_en),
   .pos_discharge(pos_discharge), .neg_discharge(neg_discharge),
   .bias_en(bias_en), .serial_en(serial_en), .regs_reset(regs_reset),
   .pos_rail_up_done(pos_rail_up_done),
   .neg_rail_up_done(neg_rail_up_done), .state(state));

// File: dps_sequencer.v
// Top-level state machine of the dual rail power sequencer.
//
// The address map and the plain strobed port are this design's own decisions.
`include "dps_consts.vh"
module dps_sequencer #(
   parameter TICK_CYC = `DPS_TICK_CYC,
   parameter DW = 8
) (
   input wire core_clk, // 100 MHz clock
   input wire rst_n, // synchronous reset, active low
   input wire por_ok, // input above power-on threshold
   input wire uvlo_clear, // input above undervoltage rise level
   input wire ovlo, // input overvoltage lockout
   input wire otlo, // overtemperature lockout
   input wire bias_good, // bias circuits good
   input wire enable_pin, // enable pin level
   input wire external_error_in_n, // external error, active low
   input wire [3:0] reg_addr, // register address
   input wire [7:0] reg_wdata, // register write data
   input wire reg_wr, // write strobe
   input wire reg_rd, // read strobe
   output reg [7:0] reg_rdata, // read data, one cycle later
   output wire pos_reg_en, // positive regulator enable
   output wire neg_reg_en, // negative regulator enable
   output wire pos_discharge, // positive active discharge on
   output wire neg_discharge, // negative active discharge on
   output wire bias_en, // bias, oscillator, detectors on
   output wire serial_en, // serial interface enabled
   output wire regs_reset, // register reset active
   output wire pos_rail_up_done, // positive power-up done flag
   output wire neg_rail_up_done, // negative power-up done flag
   output wire [2:0] state // current state
);
   // -------------------------------------------------------------------
   // Input synchronisation
   // -------------------------------------------------------------------
   wire [6:0] s;
   dps_sync #(.W(7), .INIT(7'h40)) u_sync (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .d({external_error_in_n, enable_pin, bias_good, otlo, ovlo,
          uvlo_clear, por_ok}),
      .q(s)
   );
   wire por_s = s[0];
   wire uv_ok = s[1];
   wire ov_s = s[2];
   wire ot_s = s[3];
   wire bg_s = s[4];
   wire en_s = s[5];
   wire err_n_s = s[6];
   reg err_d_r;
   wire err_fall = err_d_r & ~err_n_s;

   // -------------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------------
   reg [2:0] st_r, st_nxt;
   reg force_pos_on_r, force_neg_on_r, bias_keep_r, force_off_r;
   reg pos_discharge_enable_r, neg_discharge_enable_r;
   reg err_stat_r;
   reg [2:0] fault_cause_flags_r;
   reg [DW-1:0] pu_dly_r [0:1];
   reg [DW-1:0] pd_dly_r [0:1];
   reg [DW-1:0] cnt_r [0:1];
   reg [1:0] done_r, on_r, pd_act_r;
   reg [15:0] tick_cnt_r;
   reg tick_r;

   wire lockout = ov_s | ot_s | ~bg_s;
   wire wake = en_s | force_pos_on_r | force_neg_on_r | bias_keep_r;
   wire [1:0] frc = {force_neg_on_r, force_pos_on_r};
   wire in_reset = (st_r == `DPS_ST_NOPWR) | (st_r == `DPS_ST_UVLO);

   function [DW-1:0] dec;
      input [DW-1:0] v;
      begin
         dec = (v == {DW{1'b0}}) ? v : v - {{(DW-1){1'b0}}, 1'b1};
      end
   endfunction

   // Timebase tick so delays count in microseconds.
   always @(posedge core_clk) begin
      if (!rst_n || in_reset) begin
         tick_cnt_r <= 16'h0000;
         tick_r <= 1'b0;
      end else if (tick_cnt_r == TICK_CYC[15:0] - 16'h0001) begin
         tick_cnt_r <= 16'h0000;
         tick_r <= 1'b1;
      end else begin
         tick_cnt_r <= tick_cnt_r + 16'h0001;
         tick_r <= 1'b0;
      end
   end

   // -------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------
   wire pd_req = ~en_s & ((done_r[0] & ~frc[0]) |
                 (done_r[1] & ~frc[1]));
   wire pd_abort = en_s & (frc != 2'b00);
   wire pu_exp = (cnt_r[0] == {DW{1'b0}}) & (cnt_r[1] == {DW{1'b0}});
   wire pd_exp = ~pd_act_r[0] & ~pd_act_r[1];

   always @* begin
      st_nxt = st_r;
      case (st_r)
         `DPS_ST_NOPWR: st_nxt = `DPS_ST_UVLO;
         `DPS_ST_UVLO: if (uv_ok) st_nxt = `DPS_ST_SHDN;
         `DPS_ST_SHDN: if (wake) st_nxt = `DPS_ST_BIAS;
         `DPS_ST_BIAS: begin
            if (!wake)
               st_nxt = `DPS_ST_SHDN;
            else if (!lockout && frc == 2'b00 && en_s && !force_off_r)
               st_nxt = `DPS_ST_PUDLY;
         end
         `DPS_ST_PUDLY: begin
            if (!wake)
               st_nxt = `DPS_ST_SHDN;
            else if (lockout || force_off_r)
               st_nxt = `DPS_ST_BIAS;
            else if (pu_exp)
               st_nxt = `DPS_ST_RSON;
         end
         `DPS_ST_RSON: begin
            if (lockout)
               st_nxt = `DPS_ST_BIAS;
            else if (err_fall && en_s && (on_r == 2'b11))
               st_nxt = `DPS_ST_ERROR;
            else if (pd_req)
               st_nxt = `DPS_ST_PDDLY;
            else if (!wake)
               st_nxt = `DPS_ST_SHDN;
         end
         `DPS_ST_PDDLY: begin
            if (lockout)
               st_nxt = `DPS_ST_BIAS;
            else if (pd_abort)
               st_nxt = `DPS_ST_RSON;
            else if (pd_exp)
               st_nxt = wake ? `DPS_ST_BIAS : `DPS_ST_SHDN;
         end
         `DPS_ST_ERROR: begin
            if (err_n_s && !force_off_r)
               st_nxt = wake ? `DPS_ST_BIAS : `DPS_ST_SHDN;
         end
         default: st_nxt = `DPS_ST_NOPWR;
      endcase
      if (!por_s)
         st_nxt = `DPS_ST_NOPWR;
      else if (!uv_ok && st_r != `DPS_ST_NOPWR)
         st_nxt = `DPS_ST_UVLO;
   end

   // -------------------------------------------------------------------
   // State, counters and rail control
   // -------------------------------------------------------------------
   integer i;
   always @(posedge core_clk) begin
      if (!rst_n) begin
         st_r <= `DPS_ST_NOPWR;
         err_d_r <= 1'b1;
         done_r <= 2'b00;
         on_r <= 2'b00;
         pd_act_r <= 2'b00;
         cnt_r[0] <= {DW{1'b0}};
         cnt_r[1] <= {DW{1'b0}};
      end else begin
         st_r <= st_nxt;
         err_d_r <= err_n_s;
         if (in_reset || !por_s || lockout || st_nxt == `DPS_ST_ERROR
             || st_nxt == `DPS_ST_SHDN) begin
            on_r <= 2'b00;
            pd_act_r <= 2'b00;
            // A finished power-down that ends in shutdown still clears done.
            if (in_reset || (st_r == `DPS_ST_PDDLY && pd_exp))
               done_r <= 2'b00;
         end else begin
            for (i = 0; i < 2; i = i + 1) begin
               if (frc[i] && bg_s && !force_off_r && !lockout &&
                   !on_r[i]) begin
                  on_r[i] <= 1'b1;
                  done_r[i] <= 1'b0;
                  pd_act_r[i] <= 1'b0;
               end
            end
            if (st_r == `DPS_ST_BIAS && st_nxt == `DPS_ST_PUDLY) begin
               cnt_r[0] <= pu_dly_r[0];
               cnt_r[1] <= pu_dly_r[1];
            end else if (st_r == `DPS_ST_PUDLY && tick_r) begin
               cnt_r[0] <= dec(cnt_r[0]);
               cnt_r[1] <= dec(cnt_r[1]);
            end
            if (st_nxt == `DPS_ST_RSON && st_r == `DPS_ST_PUDLY) begin
               done_r <= 2'b11;
               on_r <= 2'b11;
            end
            if (st_r == `DPS_ST_RSON && st_nxt == `DPS_ST_PDDLY) begin
               for (i = 0; i < 2; i = i + 1) begin
                  pd_act_r[i] <= on_r[i] & ~frc[i];
                  cnt_r[i] <= pd_dly_r[i];
               end
            end else if (st_r == `DPS_ST_PDDLY) begin
               if (pd_abort) begin
                  pd_act_r <= 2'b00;
               end else begin
                  for (i = 0; i < 2; i = i + 1) begin
                     if (pd_act_r[i] && tick_r) begin
                        if (cnt_r[i] == {DW{1'b0}}) begin
                           pd_act_r[i] <= 1'b0;
                           on_r[i] <= 1'b0;
                        end else begin
                           cnt_r[i] <= dec(cnt_r[i]);
                        end
                     end
                  end
                  if (pd_exp)
                     done_r <= 2'b00;
               end
            end
         end
      end
   end

   // -------------------------------------------------------------------
   // Register file
   // -------------------------------------------------------------------
   always @(posedge core_clk) begin
      if (!rst_n || in_reset) begin
         // Fault-cause flags survive undervoltage, not power-on reset.
         if (!rst_n || st_r == `DPS_ST_NOPWR)
            fault_cause_flags_r <= 3'h0;
         else
            fault_cause_flags_r[`DPS_B_UVLO_F] <= 1'b1;
         force_pos_on_r <= 1'b0;
         force_neg_on_r <= 1'b0;
         bias_keep_r <= 1'b0;
         force_off_r <= 1'b0;
         err_stat_r <= 1'b0;
         pos_discharge_enable_r <= 1'b0;
         neg_discharge_enable_r <= 1'b0;
         pu_dly_r[0] <= `DPS_RST_DELAY;
         pu_dly_r[1] <= `DPS_RST_DELAY;
         pd_dly_r[0] <= `DPS_RST_DELAY;
         pd_dly_r[1] <= `DPS_RST_DELAY;
         reg_rdata <= 8'h00;
      end else begin
         if (reg_wr) begin
            case (reg_addr)
               `DPS_A_GLOBAL_CONFIG: begin
                  force_pos_on_r <= reg_wdata[`DPS_B_FORCE_POS_ON];
                  force_neg_on_r <= reg_wdata[`DPS_B_FORCE_NEG_ON];
                  bias_keep_r <= reg_wdata[`DPS_B_BIAS_KEEP];
                  force_off_r <= reg_wdata[`DPS_B_FORCE_OFF];
               end
               `DPS_A_CONVERTER_CONFIG: begin
                  pos_discharge_enable_r <= reg_wdata[`DPS_B_POS_DIS];
                  neg_discharge_enable_r <= reg_wdata[`DPS_B_NEG_DIS];
               end
               // Writing a one clears the matching fault-cause flag.
               `DPS_A_FAULT_CAUSE:
                  fault_cause_flags_r <= fault_cause_flags_r &
                                         ~reg_wdata[2:0];
               `DPS_A_POS_UP_DELAY: pu_dly_r[0] <= reg_wdata[DW-1:0];
               `DPS_A_NEG_UP_DELAY: pu_dly_r[1] <= reg_wdata[DW-1:0];
               `DPS_A_POS_OFF_DELAY: pd_dly_r[0] <= reg_wdata[DW-1:0];
               `DPS_A_NEG_OFF_DELAY: pd_dly_r[1] <= reg_wdata[DW-1:0];
               default: ;
            endcase
         end
         // Hardware sets come last so they win over a same-cycle clear.
         if (err_fall) begin
            err_stat_r <= 1'b1;
            force_off_r <= 1'b1;
         end else if (err_n_s) begin
            err_stat_r <= 1'b0;
         end
         if (ov_s)
            fault_cause_flags_r[`DPS_B_OVLO_F] <= 1'b1;
         if (ot_s)
            fault_cause_flags_r[`DPS_B_OTLO_F] <= 1'b1;
         reg_rdata <= 8'h00;
         if (reg_rd) begin
            case (reg_addr)
               `DPS_A_GLOBAL_CONFIG:
                  reg_rdata <= {4'h0, force_off_r, bias_keep_r,
                                force_neg_on_r, force_pos_on_r};
               `DPS_A_CONVERTER_CONFIG:
                  reg_rdata <= {6'h00, neg_discharge_enable_r,
                                pos_discharge_enable_r};
               `DPS_A_GLOBAL_STATUS:
                  reg_rdata <= {err_stat_r, done_r, on_r, st_r};
               `DPS_A_FAULT_CAUSE: reg_rdata <= {5'h00, fault_cause_flags_r};
               `DPS_A_POS_UP_DELAY: reg_rdata <= pu_dly_r[0];
               `DPS_A_NEG_UP_DELAY: reg_rdata <= pu_dly_r[1];
               `DPS_A_POS_OFF_DELAY: reg_rdata <= pd_dly_r[0];
               `DPS_A_NEG_OFF_DELAY: reg_rdata <= pd_dly_r[1];
               default: reg_rdata <= 8'h00;
            endcase
         end
      end
   end

   // -------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------
   wire in_err = (st_r == `DPS_ST_ERROR);
   wire shdn_dis = (st_r == `DPS_ST_SHDN) & ~en_s;
   assign pos_reg_en = on_r[0] & ~in_err;
   assign neg_reg_en = on_r[1] & ~in_err;
   assign pos_discharge = shdn_dis | (in_err & pos_discharge_enable_r);
   assign neg_discharge = shdn_dis | (in_err & neg_discharge_enable_r);
   assign bias_en = ~in_reset & (st_r != `DPS_ST_SHDN);
   assign serial_en = ~in_reset;
   assign regs_reset = in_reset;
   assign pos_rail_up_done = done_r[0];
   assign neg_rail_up_done = done_r[1];
   assign state = st_r;
endmodule

// File: dps_sync.v
// Two-flop synchroniser for a bus of pin levels.
module dps_sync #(
   parameter W = 1,
   parameter [W-1:0] INIT = {W{1'b0}}
) (
   input wire core_clk, // clock
   input wire rst_n, // synchronous reset, active low
   input wire [W-1:0] d, // asynchronous levels
   output reg [W-1:0] q // synchronised levels
);
   reg [W-1:0] meta_r;
   always @(posedge core_clk) begin
      if (!rst_n) begin
         meta_r <= INIT;
         q <= INIT;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule

// File: tb_top.sv
// Self-checking bench for the dual rail power state sequencer.
`include "dps_consts.vh"
`define CHK(a, e) begin \
   samples_checked++; \
   if ((a) !== (e)) begin \
      failures++; \
      $display("FAIL %0t got %h want %h", $time, a, e); \
   end \
end
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk, rst_n, por_ok, uvlo_clear;
   logic ovlo, otlo, bias_good, err_n;
   wire enable_pin, reg_wr, reg_rd, pos_reg_en, neg_reg_en, bias_en;
   wire pos_discharge, neg_discharge, serial_en, regs_reset;
   wire pos_rail_up_done, neg_rail_up_done;
   wire [3:0] reg_addr;
   wire [7:0] reg_wdata, reg_rdata;
   wire [2:0] state;
   logic [7:0] d;
   int failures = 0, samples_checked = 0, n;
   dps_sequencer #(.TICK_CYC(2)) dps_sequencer_i (.core_clk(core_clk),
      .rst_n(rst_n), .por_ok(por_ok), .uvlo_clear(uvlo_clear),
      .ovlo(ovlo), .otlo(otlo), .bias_good(bias_good),
      .enable_pin(enable_pin), .external_error_in_n(err_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pos_reg_en(pos_reg_en),
      .neg_reg_en(neg_reg_en), .pos_discharge(pos_discharge),
      .neg_discharge(neg_discharge), .bias_en(bias_en),
      .serial_en(serial_en), .regs_reset(regs_reset),
      .pos_rail_up_done(pos_rail_up_done),
      .neg_rail_up_done(neg_rail_up_done), .state(state));
   dps_host dps_host_i (.core_clk(core_clk), .enable_pin(enable_pin),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   initial begin
      core_clk = 1'h0;
      forever #5 core_clk = ~core_clk;
   end
   // -------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------
   // Bounded, so a state the design never reaches shows up as a mismatch.
   task wst(input logic [2:0] s);
      n = 0;
      while (state !== s && n < 400) begin
         @(posedge core_clk);
         n++;
      end
      `CHK(state, s)
   endtask
   task print_verdict;
      $display("comparisons %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // -------------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------------
   task t_boot;
      `CHK(regs_reset, 1'h1)
      @(posedge core_clk);
      por_ok <= 1'h1;
      wst(`DPS_ST_UVLO);
      repeat (8) @(posedge core_clk);
      `CHK(state, `DPS_ST_UVLO)
      uvlo_clear <= 1'h1;
      wst(`DPS_ST_SHDN);
      `CHK(serial_en, 1'h1)
      repeat (4) @(posedge core_clk);
      `CHK({pos_discharge, neg_discharge}, 2'h3)
      dps_host_i.wr(`DPS_A_POS_OFF_DELAY, 8'h02);
      dps_host_i.wr(`DPS_A_NEG_OFF_DELAY, 8'h06);
      dps_host_i.rd(4'hF, d);
      `CHK(d, 8'h00)
      $display("boot done");
   endtask
   task t_up_down;
      dps_host_i.en(1'h1);
      wst(`DPS_ST_BIAS);
      `CHK({bias_en, pos_reg_en, neg_reg_en}, 3'h4)
      wst(`DPS_ST_PUDLY);
      wst(`DPS_ST_RSON);
      `CHK({pos_rail_up_done, neg_rail_up_done}, 2'h3)
      dps_host_i.en(1'h0);
      wst(`DPS_ST_PDDLY);
      n = 0;
      while (pos_reg_en === 1'h1 && n < 100) begin
         @(posedge core_clk);
         n++;
      end
      `CHK({pos_reg_en, neg_reg_en}, 2'h1)
      wst(`DPS_ST_SHDN);
      `CHK({pos_rail_up_done, neg_rail_up_done}, 2'h0)
      $display("up down done");
   endtask
   task t_abort;
      dps_host_i.en(1'h1);
      wst(`DPS_ST_RSON);
      dps_host_i.en(1'h0);
      wst(`DPS_ST_PDDLY);
      dps_host_i.wr(`DPS_A_GLOBAL_CONFIG, 8'h01);
      dps_host_i.en(1'h1);
      wst(`DPS_ST_RSON);
      repeat (20) @(posedge core_clk);
      `CHK({pos_reg_en, neg_reg_en}, 2'h3)
      dps_host_i.wr(`DPS_A_GLOBAL_CONFIG, 8'h00);
      $display("abort done");
   endtask
   task t_error;
      dps_host_i.wr(`DPS_A_CONVERTER_CONFIG, 8'h03);
      err_n <= 1'h0;
      wst(`DPS_ST_ERROR);
      `CHK({pos_reg_en, neg_reg_en}, 2'h0)
      `CHK({pos_discharge, neg_discharge}, 2'h3)
      dps_host_i.rd(`DPS_A_GLOBAL_CONFIG, d);
      `CHK(d[`DPS_B_FORCE_OFF], 1'h1)
      dps_host_i.rd(`DPS_A_GLOBAL_STATUS, d);
      `CHK(d[7], 1'h1)
      err_n <= 1'h1;
      repeat (8) @(posedge core_clk);
      `CHK(state, `DPS_ST_ERROR)
      dps_host_i.wr(`DPS_A_GLOBAL_CONFIG, 8'h00);
      wst(`DPS_ST_RSON);
      dps_host_i.wr(`DPS_A_CONVERTER_CONFIG, 8'h00);
      $display("error done");
   endtask
   task t_force;
      dps_host_i.en(1'h0);
      wst(`DPS_ST_SHDN);
      dps_host_i.wr(`DPS_A_GLOBAL_CONFIG, 8'h02);
      repeat (8) @(posedge core_clk);
      `CHK({pos_reg_en, neg_reg_en, neg_rail_up_done}, 3'h2)
      dps_host_i.wr(`DPS_A_GLOBAL_CONFIG, 8'h00);
      wst(`DPS_ST_SHDN);
      $display("force done");
   endtask
   task t_lock;
      dps_host_i.en(1'h1);
      wst(`DPS_ST_RSON);
      otlo <= 1'h1;
      repeat (6) @(posedge core_clk);
      `CHK({pos_reg_en, neg_reg_en}, 2'h0)
      dps_host_i.rd(`DPS_A_FAULT_CAUSE, d);
      `CHK(d[`DPS_B_OTLO_F], 1'h1)
      otlo <= 1'h0;
      wst(`DPS_ST_RSON);
      ovlo <= 1'h1;
      repeat (6) @(posedge core_clk);
      `CHK({pos_reg_en, neg_reg_en}, 2'h0)
      ovlo <= 1'h0;
      wst(`DPS_ST_RSON);
      bias_good <= 1'h0;
      repeat (6) @(posedge core_clk);
      `CHK({pos_reg_en, neg_reg_en}, 2'h0)
      bias_good <= 1'h1;
      wst(`DPS_ST_RSON);
      por_ok <= 1'h0;
      wst(`DPS_ST_NOPWR);
      `CHK({regs_reset, serial_en}, 2'h2)
      $display("lockout done");
   endtask
   initial begin
      rst_n = 1'h0;
      por_ok = 1'h0;
      uvlo_clear = 1'h0;
      ovlo = 1'h0;
      otlo = 1'h0;
      bias_good = 1'h1;
      err_n = 1'h1;
      repeat (5) @(posedge core_clk);
      rst_n <= 1'h1;
      t_boot;
      t_up_down;
      t_abort;
      t_error;
      t_force;
      t_lock;
      print_verdict;
   end
   initial begin
      #100us;
      failures++;
      $display("FAIL %0t watchdog expired", $time);
      print_verdict;
   end
endmodule
